// [bench/uim_core_test.sv]
// Self-checking bench of the UART interrupt and modem block.
// Assumes uim_defs.svh and uim_pkg are compiled first.
`timescale 1ns/100ps
`include "uim_defs.svh"
module uim_core_test;
    import uim_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:2] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic ack;
    uim_dp_t dp;
    uim_dp_t base;
    uim_dp_t p;
    uim_min_t want = 4'hF;
    uim_min_t modem_in;
    uim_mout_t mout;
    logic sin_want = 1'b1;
    logic serial_input, int_sel_n = 1'b1;
    logic serial_output, rx_sin, irq, irq_oe, sleep, b16, irda, xany, aflow;
    logic [7:0] q;
    int error_cnt = 0;
    int comparisons = 0;
    always #10 clk_i = ~clk_i;
    uim_core uim_core_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dp_i(dp), .modem_in_i(modem_in), .serial_input_i(serial_input), .int_sel_n_i(int_sel_n),
        .modem_out_o(mout), .serial_output_o(serial_output), .rx_sin_o(rx_sin), .irq_o(irq), .irq_oe_o(irq_oe),
        .sleep_o(sleep), .baud16_o(b16), .irda_en_o(irda), .xon_any_o(xany), .auto_flow_o(aflow));
    uim_line_partner uim_line_partner_inst (.clk_i(clk_i), .want_i(want), .sin_want_i(sin_want),
        .modem_in_o(modem_in), .serial_input_o(serial_input));
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until the rising edge at which ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        sel <= 4'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("bus ack cycles", 16'h0002, n[15:0]);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
        bus(1'b0, a, 8'h00);
        chk(s, {8'h00, e}, {8'h00, q & m});
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic pulse(input uim_dp_t v);
        @(posedge clk_i);
        dp <= v;
        @(posedge clk_i);
        dp <= base;
        tick(2);
    endtask
    task automatic baud_gap(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] e);
        int n;
        wr(`UIM_IDX_DLL, lo);
        wr(`UIM_IDX_DLM, hi);
        n = 0;
        tick(2);
        while (b16 !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        n = 0;
        do begin
            tick(1);
            n++;
        end while (b16 !== 1'b1 && n < 600);
        chk("baud gap", e, n[15:0]);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(`UIM_IDX_CPR, 8'hFF, 8'h20, "prescale");
        rd(`UIM_IDX_DLL, 8'hFF, 8'h01, "divisor low");
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_NONE, "isr idle");
        rd(4'h9, 8'hFF, 8'h00, "unmapped");
        chk("modem out", 16'h000C, {12'h000, mout});
        $display("test reset done");
    endtask
    task automatic t_mcr();
        wr(`UIM_IDX_MCR, 8'h0F);
        chk("modem out", 16'h0003, {12'h000, mout});
        @(posedge clk_i);
        int_sel_n <= 1'b0;
        tick(1);
        chk("irq oe", 16'h0001, {15'h0000, irq_oe});
        wr(`UIM_IDX_MCR, 8'h07);
        chk("irq oe", 16'h0000, {15'h0000, irq_oe});
        chk("modem out", 16'h0002, {12'h000, mout});
        wr(`UIM_IDX_MCR, 8'hE0);
        rd(`UIM_IDX_MCR, 8'h80, 8'h00, "prescale select");
        chk("flow modes", 16'h0001, {13'h0000, irda, xany, aflow});
        wr(`UIM_IDX_MODE, 8'h01);
        wr(`UIM_IDX_MCR, 8'hE0);
        rd(`UIM_IDX_MCR, 8'h80, 8'h80, "prescale select");
        chk("flow modes", 16'h0006, {13'h0000, irda, xany, aflow});
        wr(`UIM_IDX_MCR, 8'h00);
        wr(`UIM_IDX_MODE, 8'h00);
        @(posedge clk_i);
        int_sel_n <= 1'b1;
        $display("test modem control done");
    endtask
    task automatic t_modem();
        wr(`UIM_IDX_IER, 8'h08);
        bus(1'b0, `UIM_IDX_MSR, 8'h00);
        @(posedge clk_i);
        want.cts_n <= 1'b0;
        tick(3);
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_MDM, "isr modem");
        rd(`UIM_IDX_MSR, 8'hFF, 8'h11, "msr cts");
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_NONE, "isr cleared");
        @(posedge clk_i);
        want.ri_n <= 1'b0;
        tick(3);
        rd(`UIM_IDX_MSR, 8'hFF, 8'h50, "msr ring lead");
        @(posedge clk_i);
        want <= 4'hF;
        tick(3);
        rd(`UIM_IDX_MSR, 8'hFF, 8'h05, "msr ring trail");
        wr(`UIM_IDX_MODE, 8'h01);
        wr(`UIM_IDX_IER, 8'h80);
        bus(1'b0, `UIM_IDX_ISR, 8'h00);
        @(posedge clk_i);
        want.cts_n <= 1'b0;
        tick(3);
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_NONE, "isr cts fall");
        @(posedge clk_i);
        want.cts_n <= 1'b1;
        tick(3);
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_CTRT, "isr cts rise");
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_NONE, "isr cts cleared");
        bus(1'b0, `UIM_IDX_MSR, 8'h00);
        wr(`UIM_IDX_MODE, 8'h00);
        $display("test modem status done");
    endtask
    task automatic t_loop();
        wr(`UIM_IDX_MCR, 8'h13);
        @(posedge clk_i);
        dp.tx_serial_output <= 1'b0;
        sin_want <= 1'b0;
        tick(3);
        chk("modem out", 16'h000F, {12'h000, mout});
        chk("loop serial", 16'h0002, {14'h0000, serial_output, rx_sin});
        rd(`UIM_IDX_MSR, 8'hFF, 8'h33, "msr loop");
        @(posedge clk_i);
        dp.tx_serial_output <= 1'b1;
        sin_want <= 1'b1;
        wr(`UIM_IDX_MCR, 8'h00);
        bus(1'b0, `UIM_IDX_MSR, 8'h00);
        $display("test loopback done");
    endtask
    task automatic t_line();
        wr(`UIM_IDX_IER, 8'h05);
        base.rx_above_trig = 1'b1;
        p = base;
        p.ovr = 1'b1;
        pulse(p);
        chk("irq", 16'h0001, {15'h0000, irq});
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_RXST, "isr status");
        rd(`UIM_IDX_LSR, 8'h1E, 8'h02, "lsr overrun");
        rd(`UIM_IDX_LSR, 8'h1E, 8'h00, "lsr cleared");
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_RXAV, "isr data");
        base.rx_above_trig = 1'b0;
        wr(`UIM_IDX_IER, 8'h01);
        p = base;
        p.frm = 1'b1;
        pulse(p);
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_NONE, "isr masked");
        bus(1'b0, `UIM_IDX_LSR, 8'h00);
        @(posedge clk_i);
        ce <= 1'b0;
        pulse(p);
        @(posedge clk_i);
        ce <= 1'b1;
        rd(`UIM_IDX_LSR, 8'h9E, 8'h00, "lsr frozen");
        wr(`UIM_IDX_MODE, 8'h06);
        wr(`UIM_IDX_IER, 8'h04);
        p = base;
        p.ovr = 1'b1;
        pulse(p);
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_NONE, "isr nine masked");
        bus(1'b0, `UIM_IDX_LSR, 8'h00);
        p = base;
        p.addr_bit = 1'b1;
        pulse(p);
        rd(`UIM_IDX_ISR, 8'h3F, `UIM_ISR_RXST, "isr address bit");
        rd(`UIM_IDX_LSR, 8'h9E, 8'h04, "lsr address bit");
        wr(`UIM_IDX_MODE, 8'h00);
        $display("test line status done");
    endtask
    task automatic t_sleep();
        wr(`UIM_IDX_IER, 8'h10);
        tick(4);
        chk("sleep", 16'h0001, {15'h0000, sleep});
        rd(`UIM_IDX_IER, 8'h10, 8'h10, "sleep readback");
        @(posedge clk_i);
        sin_want <= 1'b0;
        tick(4);
        chk("sleep", 16'h0000, {15'h0000, sleep});
        rd(`UIM_IDX_IER, 8'h10, 8'h00, "sleep readback");
        @(posedge clk_i);
        sin_want <= 1'b1;
        wr(`UIM_IDX_MODE, 8'h01);
        wr(`UIM_IDX_MCR, 8'h40);
        tick(4);
        chk("sleep irda", 16'h0000, {15'h0000, sleep});
        wr(`UIM_IDX_MCR, 8'h00);
        tick(4);
        chk("sleep", 16'h0001, {15'h0000, sleep});
        wr(`UIM_IDX_IER, 8'h00);
        tick(2);
        chk("sleep off", 16'h0000, {15'h0000, sleep});
        wr(`UIM_IDX_MODE, 8'h00);
        $display("test sleep done");
    endtask
    // ==========================================
    // Run control
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        $display("unexpected watchdog: expected finish seen timeout");
        summarize();
    end
    initial begin
        base = '0;
        base.tx_fifo_empty = 1'b1;
        base.tx_shift_empty = 1'b1;
        base.tx_serial_output = 1'b1;
        base.rx_idle = 1'b1;
        base.char_bits = 4'hA;
        dp = base;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mcr();
        t_modem();
        t_loop();
        t_line();
        t_sleep();
        baud_gap(8'h03, 8'h00, 16'h0003);
        baud_gap(8'h02, 8'h01, 16'h0102);
        $display("test baud done");
        summarize();
    end
endmodule

// [bench/uim_line_partner.sv]
// Modem handshake and serial line partner for the bench.
// Assumes the bench sets the wanted line levels; lines idle high.
`timescale 1ns/100ps
module uim_line_partner
    import uim_pkg::*;
(
    input wire logic clk_i,
    input wire uim_min_t want_i,
    input wire logic sin_want_i,
    output uim_min_t modem_in_o,
    output logic serial_input_o
);
    // ==========================================
    // Line drivers
    // Lines move just after an edge, as a real modem would
    initial begin
        modem_in_o = 4'hF;
        serial_input_o = 1'b1;
    end
    always @(posedge clk_i) begin
        modem_in_o <= want_i;
        serial_input_o <= sin_want_i;
    end
endmodule

// [core/uim_core.sv]
// UART channel interrupt, sleep, modem and baud rate logic.
// Assumes a receiver/transmitter datapath supplies status and
// a classic Wishbone master reaches the registers.
// Function
// - Report only highest-priority pending source; 000001 when none.
// - Normal framing: line status bits 1-4 raise level 1 under enable bit 2.
// - Nine-bit: errors gated by enable bit 3, address bit by mode bit.
// - Level 2a while receive fill exceeds its trigger.
// - Level 2b after four idle character periods; first read clears.
// - Level 3 on transmit level under trigger; read or refill clears.
// - Zero trigger with extended levels waits for fully idle transmitter.
// - Level 4 from modem deltas; modem status read clears.
// - Level 5 only in enhanced mode; status read of level 5 clears.
// - Level 6 on CTS or RTS low-to-high, only in enhanced mode; status read clears.
// - Sleep only when enabled and every idle condition holds.
// - Sleep readback shows entry; leaves sleep when conditions fail.
// - Never sleep in infrared mode.
// - Control bits 0,1 drive DTR and RTS active low.
// - Bits 2,3 drive user outputs; bit 3 gates interrupt pin by select.
// - Loopback holds outputs high and wires outputs back internally.
// - Bit 5 is resume-on-any in enhanced, else CTS/RTS flow control.
// - Bit 6 selects infrared coding in enhanced mode; needs 16x clock.
// - Bit 7 selects M+N/8 prescaler; reset 0x20; writes need enhanced.
// - Deltas for CTS, DSR, DCD changes; ring trailing edge only.
// - Status bits 4-7 show inverted inputs or loopback sources.
// - Baud tick divides by divisor 1 to 65535 from two bytes.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
module uim_core
    import uim_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire uim_dp_t dp_i,
    input wire uim_min_t modem_in_i,
    input wire logic serial_input_i,
    input wire logic int_sel_n_i,
    output uim_mout_t modem_out_o,
    output logic serial_output_o,
    output logic rx_sin_o,
    output logic irq_o,
    output logic irq_oe_o,
    output logic sleep_o,
    output logic baud16_o,
    output logic irda_en_o,
    output logic xon_any_o,
    output logic auto_flow_o
);
`include "uim_defs.svh"

    // ==========================================
    // Decode
    uim_st_t s;
    uim_st_t n;
    logic req;
    logic wr;
    logic rd_isr;
    logic rd_lsr;
    logic rd_msr;
    logic loop;
    logic enh;
    logic nine;
    logic [3:0] m_in;
    logic [3:0] chg;
    logic [5:0] code;
    logic [7:0] src;
    logic tx_cond;
    logic [9:0] tmo_lim;
    logic [15:0] div_eff;
    logic [7:0] cpr_eff;
    logic [8:0] acc9;
    logic pre_tick;
    logic irda_on;
    logic sleep_en;
    logic sleep_ok;
    logic [1:0] ctsrts;
    logic [7:0] ier_rd;
    logic [7:0] rd_val;

    assign req = wb_cyc_i & wb_stb_i & ~s.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd_isr = req & ~wb_we_i & (wb_adr_i == `UIM_IDX_ISR);
    assign rd_lsr = req & ~wb_we_i & (wb_adr_i == `UIM_IDX_LSR);
    assign rd_msr = req & ~wb_we_i & (wb_adr_i == `UIM_IDX_MSR);
    assign loop = s.modem_control[`UIM_MCR_LOOP];
    assign enh = s.mode.enh;
    assign nine = s.mode.nine;

    // ==========================================
    // Modem view: index 0 CTS, 1 DSR, 2 RI, 3 DCD
    always_comb begin
        if (loop) begin
            m_in = {s.modem_control[`UIM_MCR_USER_OUTPUT_TWO], s.modem_control[`UIM_MCR_USER_OUTPUT_ONE],
                    s.modem_control[`UIM_MCR_DTR], s.modem_control[`UIM_MCR_RTS]};
        end else begin
            m_in = ~{modem_in_i.dcd_n, modem_in_i.ri_n,
                     modem_in_i.dsr_n, modem_in_i.cts_n};
        end
    end

    assign chg[0] = m_in[0] ^ s.mprev[0];
    assign chg[1] = m_in[1] ^ s.mprev[1];
    assign chg[2] = s.mprev[2] & ~m_in[2];
    assign chg[3] = m_in[3] ^ s.mprev[3];

    // ==========================================
    // Pins
    always_comb begin
        modem_out_o.dtr_n = loop | ~s.modem_control[`UIM_MCR_DTR];
        modem_out_o.rts_n = loop | ~s.modem_control[`UIM_MCR_RTS];
        modem_out_o.user_output_one_n = loop | s.modem_control[`UIM_MCR_USER_OUTPUT_ONE];
        modem_out_o.user_output_two_n = loop | s.modem_control[`UIM_MCR_USER_OUTPUT_TWO];
    end
    assign serial_output_o = loop | dp_i.tx_serial_output;
    assign rx_sin_o = loop ? dp_i.tx_serial_output : serial_input_i;
    assign irda_on = s.modem_control[`UIM_MCR_IRDA] & enh;
    assign irda_en_o = irda_on;
    assign xon_any_o = s.modem_control[`UIM_MCR_XANY] & enh;
    assign auto_flow_o = s.modem_control[`UIM_MCR_XANY] & ~enh;
    // CTS as seen after loopback, RTS as driven
    assign ctsrts = {modem_out_o.rts_n, ~m_in[0]};

    // ==========================================
    // Transmit empty condition
    always_comb begin
        if (s.mode.ext_trig & dp_i.ttl_zero) begin
            tx_cond = dp_i.tx_fifo_empty & dp_i.tx_shift_empty & dp_i.tx_serial_output;
        end else begin
            tx_cond = dp_i.tx_below_trig;
        end
    end

    // ==========================================
    // Interrupt sources in priority order, bit 0 highest
    always_comb begin
        if (nine) begin
            src[0] = ((s.line_status[1] | s.line_status[3] | s.line_status[4]) & s.interrupt_enable[`UIM_IER_MDM])
                     | (s.line_status[2] & s.mode.addr_int);
        end else begin
            src[0] = (|s.line_status) & s.interrupt_enable[`UIM_IER_RXST];
        end
        src[1] = dp_i.rx_above_trig & s.interrupt_enable[`UIM_IER_RXAV];
        src[2] = s.tmo & s.interrupt_enable[`UIM_IER_RXAV];
        src[3] = s.lvl3 & s.interrupt_enable[`UIM_IER_TXEM];
        src[4] = (|s.dlt) & s.interrupt_enable[`UIM_IER_MDM];
        src[5] = s.lvl5 & s.interrupt_enable[`UIM_IER_ALT] & enh;
        src[6] = enh & ((s.lvl6[0] & s.interrupt_enable[`UIM_IER_CTS])
                 | (s.lvl6[1] & s.interrupt_enable[`UIM_IER_RTS]));
        src[7] = 1'b0;
    end

    always_comb begin
        if (src[0]) begin
            code = `UIM_ISR_RXST;
        end else if (src[1]) begin
            code = `UIM_ISR_RXAV;
        end else if (src[2]) begin
            code = `UIM_ISR_RXTO;
        end else if (src[3]) begin
            code = `UIM_ISR_TXEM;
        end else if (src[4]) begin
            code = `UIM_ISR_MDM;
        end else if (src[5]) begin
            code = `UIM_ISR_SPCH;
        end else if (src[6]) begin
            code = `UIM_ISR_CTRT;
        end else begin
            code = `UIM_ISR_NONE;
        end
    end

    assign irq_o = |src;
    // Interrupt pin only tristates when select is low
    assign irq_oe_o = int_sel_n_i | s.modem_control[`UIM_MCR_USER_OUTPUT_TWO];

    // ==========================================
    // Sleep
    assign sleep_en = (s.mode.alt_sleep & ~enh) ? s.interrupt_enable[`UIM_IER_ALT] : s.interrupt_enable[`UIM_IER_SLEEP];
    assign sleep_ok = sleep_en & dp_i.tx_fifo_empty & dp_i.tx_shift_empty
                      & serial_input_i & dp_i.rx_idle & ~dp_i.rx_held
                      & ~loop & (s.dlt == 4'h0) & ~(|src)
                      & ~irda_on;
    assign sleep_o = s.asleep;

    always_comb begin
        ier_rd = s.interrupt_enable;
        if (s.mode.alt_sleep & ~enh) begin
            ier_rd[`UIM_IER_ALT] = s.interrupt_enable[`UIM_IER_ALT] & s.asleep;
        end else begin
            ier_rd[`UIM_IER_SLEEP] = s.interrupt_enable[`UIM_IER_SLEEP] & s.asleep;
        end
    end

    // ==========================================
    // Baud generation
    assign cpr_eff = (s.clock_prescale < 8'h08) ? 8'h08 : s.clock_prescale;
    assign acc9 = {1'b0, s.pre_acc} + `UIM_PRE_STEP;
    assign pre_tick = ~s.modem_control[`UIM_MCR_PRE] | (acc9 >= {1'b0, cpr_eff});
    assign div_eff = ({s.divisor_high, s.dll} == 16'h0000) ? 16'h0001 : {s.divisor_high, s.dll};
    assign baud16_o = s.b16;
    assign tmo_lim = 10'(`UIM_TO_CHARS * `UIM_OVERSAMPLE * dp_i.char_bits);

    // ==========================================
    // Register read mux
    always_comb begin
        case (wb_adr_i)
            `UIM_IDX_IER: rd_val = ier_rd;
            `UIM_IDX_CPR: rd_val = s.clock_prescale;
            `UIM_IDX_ISR: rd_val = {2'h0, code};
            `UIM_IDX_LSR: rd_val = {s.lsr7, dp_i.tx_fifo_empty & dp_i.tx_shift_empty,
                                    dp_i.tx_fifo_empty, s.line_status, dp_i.rx_held};
            `UIM_IDX_MCR: rd_val = s.modem_control;
            `UIM_IDX_MSR: rd_val = {m_in, s.dlt};
            `UIM_IDX_DLL: rd_val = s.dll;
            `UIM_IDX_DLM: rd_val = s.divisor_high;
            `UIM_IDX_MODE: rd_val = {2'h0, s.mode};
            default: rd_val = 8'h00;
        endcase
    end
    assign wb_dat_o = {24'h000000, s.rdata};
    assign wb_ack_o = s.ack;

    // ==========================================
    // Next state
    always_comb begin
        n = s;
        n.ack = req;
        if (req & ~wb_we_i) begin
            n.rdata = rd_val;
        end
        if (wr) begin
            case (wb_adr_i)
                `UIM_IDX_IER: n.interrupt_enable = wb_dat_i[7:0];
                `UIM_IDX_CPR: n.clock_prescale = wb_dat_i[7:0];
                `UIM_IDX_MCR: n.modem_control = {enh ? wb_dat_i[7] : s.modem_control[7], wb_dat_i[6:0]};
                `UIM_IDX_DLL: n.dll = wb_dat_i[7:0];
                `UIM_IDX_DLM: n.divisor_high = wb_dat_i[7:0];
                `UIM_IDX_MODE: n.mode = uim_mode_t'(wb_dat_i[5:0]);
                default: n.rdata = s.rdata;
            endcase
        end
        // Line status: set wins over the read clear
        n.line_status = (rd_lsr ? 4'h0 : s.line_status)
                | {dp_i.brk, dp_i.frm, nine ? dp_i.addr_bit : dp_i.par, dp_i.ovr};
        n.lsr7 = (rd_lsr ? 1'b0 : s.lsr7)
                 | dp_i.frm | dp_i.brk | (~nine & dp_i.par);
        // Modem deltas
        n.mprev = m_in;
        n.dlt = (rd_msr ? 4'h0 : s.dlt) | chg;
        // Transmit empty
        n.tx_prev = tx_cond;
        n.lvl3 = (tx_cond & ~s.tx_prev)
                 | (s.lvl3 & tx_cond & ~(rd_isr & (code == `UIM_ISR_TXEM)));
        // Special character
        n.lvl5 = (enh & dp_i.l5_event)
                 | (s.lvl5 & ~(rd_isr & (code == `UIM_ISR_SPCH)));
        // CTS/RTS rising
        n.ctsrts_prev = ctsrts;
        n.lvl6 = (ctsrts & ~s.ctsrts_prev)
                 | (s.lvl6 & ~{2{rd_isr & (code == `UIM_ISR_CTRT)}});
        // Receive time-out
        if (dp_i.rx_stop_ctr | dp_i.rx_first_read) begin
            n.tmo_on = 1'b1;
            n.tmo_cnt = 10'h000;
        end else if (s.b16 & s.tmo_on & (s.tmo_cnt < tmo_lim)) begin
            n.tmo_cnt = s.tmo_cnt + 10'h001;
        end
        if (dp_i.rx_first_read | ~dp_i.rx_held) begin
            n.tmo = 1'b0;
        end else if (s.mode.fifo_mode & s.tmo_on & (s.tmo_cnt >= tmo_lim)) begin
            n.tmo = 1'b1;
        end
        // Prescaler and divisor
        n.b16 = 1'b0;
        if (s.modem_control[`UIM_MCR_PRE]) begin
            n.pre_acc = pre_tick ? 8'(acc9 - {1'b0, cpr_eff}) : acc9[7:0];
        end else begin
            n.pre_acc = 8'h00;
        end
        if (pre_tick) begin
            if (s.bcnt >= div_eff - 16'h0001) begin
                n.bcnt = 16'h0000;
                n.b16 = 1'b1;
            end else begin
                n.bcnt = s.bcnt + 16'h0001;
            end
        end
        n.asleep = sleep_ok;
    end

    // ==========================================
    // State register, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{clock_prescale: `UIM_CPR_RST, dll: `UIM_DLL_RST, default: '0};
        end else if (ce_i) begin
            s <= n;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_none_code;
        (src == 8'h00) |-> (code == `UIM_ISR_NONE) && !irq_o;
    endproperty
    a_none_code: assert property (p_none_code) else $error("idle code wrong");

    property p_lsr_clear;
        ce_i && rd_lsr && !(dp_i.ovr | dp_i.par | dp_i.frm | dp_i.brk | dp_i.addr_bit)
        |=> (s.line_status == 4'h0) && !s.lsr7;
    endproperty
    a_lsr_clear: assert property (p_lsr_clear) else $error("line status not cleared");

    property p_nine_par;
        ce_i && nine && dp_i.addr_bit && !dp_i.frm && !dp_i.brk && !s.lsr7 |=> !s.lsr7 && s.line_status[2];
    endproperty
    a_nine_par: assert property (p_nine_par) else $error("ninth bit set error flag");

    property p_msr_clear;
        ce_i && rd_msr && (chg == 4'h0) |=> (s.dlt == 4'h0) && (src[4] == 1'b0);
    endproperty
    a_msr_clear: assert property (p_msr_clear) else $error("modem deltas not cleared");

    property p_loop_pins;
        loop |-> serial_output_o && modem_out_o.dtr_n && modem_out_o.rts_n
                 && (m_in[0] == s.modem_control[`UIM_MCR_RTS]) && (rx_sin_o == dp_i.tx_serial_output);
    endproperty
    a_loop_pins: assert property (p_loop_pins) else $error("loopback wiring wrong");

    property p_irda_sleep;
        ce_i && irda_on |=> !sleep_o;
    endproperty
    a_irda_sleep: assert property (p_irda_sleep) else $error("slept in infrared mode");

    property p_sleep_exit;
        ce_i && sleep_o && (|src) |=> !sleep_o;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep kept with pending source");

    property p_cpr_reset;
        $past(rst_i) |-> (s.clock_prescale == `UIM_CPR_RST) && !s.modem_control[`UIM_MCR_PRE];
    endproperty
    a_cpr_reset: assert property (p_cpr_reset) else $error("prescaler reset value wrong");

    property p_baud_gap;
        ce_i && baud16_o && (div_eff > 16'h0001) |=> !baud16_o;
    endproperty
    a_baud_gap: assert property (p_baud_gap) else $error("baud tick too close");

    property p_cts_rise;
        ce_i && ctsrts[0] && !s.ctsrts_prev[0] |=> s.lvl6[0];
    endproperty
    a_cts_rise: assert property (p_cts_rise) else $error("CTS rise missed");

    property p_lvl6_clear;
        ce_i && rd_isr && (code == `UIM_ISR_CTRT) && ((ctsrts & ~s.ctsrts_prev) == 2'h0) |=> (s.lvl6 == 2'h0);
    endproperty
    a_lvl6_clear: assert property (p_lvl6_clear) else $error("level 6 not cleared");

    property p_dtr_drive;
        !loop && s.modem_control[`UIM_MCR_DTR] |-> !modem_out_o.dtr_n && !modem_out_o.user_output_one_n == !s.modem_control[2];
    endproperty
    a_dtr_drive: assert property (p_dtr_drive) else $error("DTR level wrong");
endmodule

// [core/uim_defs.svh]
// Offsets, fields, reset values and counts of the UART interrupt and modem block.
// Assumes the including file handles sizing; definitions only.
`ifndef UIM_DEFS_SVH
`define UIM_DEFS_SVH
// ==========================================
// Register word indices (byte address is index * 4)
`define UIM_IDX_IER 4'h0
`define UIM_IDX_CPR 4'h1
`define UIM_IDX_ISR 4'h2
`define UIM_IDX_LSR 4'h3
`define UIM_IDX_MCR 4'h4
`define UIM_IDX_MSR 4'h5
`define UIM_IDX_DLL 4'h6
`define UIM_IDX_DLM 4'h7
`define UIM_IDX_MODE 4'h8
// ==========================================
// Reset values
`define UIM_CPR_RST 8'h20
`define UIM_DLL_RST 8'h01
// ==========================================
// Interrupt status codes
`define UIM_ISR_NONE 6'h01
`define UIM_ISR_RXST 6'h06
`define UIM_ISR_RXAV 6'h04
`define UIM_ISR_RXTO 6'h0C
`define UIM_ISR_TXEM 6'h02
`define UIM_ISR_MDM 6'h00
`define UIM_ISR_SPCH 6'h10
`define UIM_ISR_CTRT 6'h20
// ==========================================
// Field positions
`define UIM_IER_RXAV 0
`define UIM_IER_TXEM 1
`define UIM_IER_RXST 2
`define UIM_IER_MDM 3
`define UIM_IER_SLEEP 4
`define UIM_IER_ALT 5
`define UIM_IER_RTS 6
`define UIM_IER_CTS 7
`define UIM_MCR_DTR 0
`define UIM_MCR_RTS 1
`define UIM_MCR_USER_OUTPUT_ONE 2
`define UIM_MCR_USER_OUTPUT_TWO 3
`define UIM_MCR_LOOP 4
`define UIM_MCR_XANY 5
`define UIM_MCR_IRDA 6
`define UIM_MCR_PRE 7
// ==========================================
// Timing counts
`define UIM_TO_CHARS 4
`define UIM_OVERSAMPLE 16
`define UIM_PRE_STEP 9'h008
`endif

// [core/uim_pkg.sv]
// Types of the UART interrupt and modem block.
// Assumes uim_defs.svh holds all numbers.
package uim_pkg;
    // ==========================================
    // Datapath status from receiver and transmitter
    typedef struct packed {
        logic ovr;
        logic par;
        logic frm;
        logic brk;
        logic addr_bit;
        logic rx_above_trig;
        logic rx_held;
        logic rx_stop_ctr;
        logic rx_first_read;
        logic rx_idle;
        logic tx_below_trig;
        logic tx_fifo_empty;
        logic tx_shift_empty;
        logic tx_serial_output;
        logic l5_event;
        logic ttl_zero;
        logic [3:0] char_bits;
    } uim_dp_t;
    // Modem inputs, active low
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic dcd_n;
    } uim_min_t;
    // Modem outputs; DTR and RTS active low, user outputs follow their control bits
    typedef struct packed {
        logic dtr_n;
        logic rts_n;
        logic user_output_one_n;
        logic user_output_two_n;
    } uim_mout_t;
    // Mode register
    typedef struct packed {
        logic fifo_mode;
        logic alt_sleep;
        logic ext_trig;
        logic addr_int;
        logic nine;
        logic enh;
    } uim_mode_t;
    // ==========================================
    // Whole module state
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic [7:0] interrupt_enable;
        logic [7:0] modem_control;
        logic [7:0] clock_prescale;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        uim_mode_t mode;
        logic [4:1] line_status;
        logic lsr7;
        logic [3:0] dlt;
        logic [3:0] mprev;
        logic [1:0] ctsrts_prev;
        logic [1:0] lvl6;
        logic lvl3;
        logic lvl5;
        logic tx_prev;
        logic tmo_on;
        logic [9:0] tmo_cnt;
        logic tmo;
        logic [7:0] pre_acc;
        logic [15:0] bcnt;
        logic b16;
        logic asleep;
    } uim_st_t;
endpackage
